// ### hdl/hsmm_meas_mem.sv
`timescale 1ns/100ps
`default_nettype none
module hsmm_meas_mem import hsmm_pkg::*; #(
   parameter int ENTRIES = 6
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // Store port
   hsmm_mem_if.store mem
);

   // ************************************************
   // Entry storage, float over integer
   // ************************************************
   logic [47:0] ent [ENTRIES];
   logic [47:0] next_ent [ENTRIES];
   logic [47:0] next_rdData;

   for (genvar g = 0; g < ENTRIES; g++) begin : g_ent
      // Next value of one entry
      always_comb begin
         next_ent[g] = ent[g];
         if (mem.wrEn && mem.wrIdx == 3'(g)) begin
            next_ent[g] = {mem.wrFloat, mem.wrInt}; // see RULE1
         end
      end

      // Entry register
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            ent[g] <= 48'h0;
         end else if (ce) begin
            ent[g] <= next_ent[g];
         end
      end
   end

   // ************************************************
   // Registered read port
   // ************************************************
   always_comb begin
      next_rdData = mem.rdData;
      if (mem.rdEn) begin
         next_rdData = (mem.rdIdx < 3'(ENTRIES)) ? ent[mem.rdIdx] : 48'h0;
      end
   end

   // Read data register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mem.rdData <= 48'h0;
      end else if (ce) begin
         mem.rdData <= next_rdData;
      end
   end

   // Written pair lands whole in its own entry
   property p_mem_keep;
      @(posedge ref_clk) disable iff (rst)
      (ce && mem.wrEn && mem.wrIdx < 3'(ENTRIES))
         |=> (ent[$past(mem.wrIdx)] == $past({mem.wrFloat, mem.wrInt}));
   endproperty
   a_mem_keep: assert property (p_mem_keep) else $error("stored pair lost"); // see RULE1

endmodule
`default_nettype wire

// ### hdl/hsmm_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hsmm_mem_if;
   import hsmm_pkg::*;
   logic wrEn;
   hsmm_idx_t wrIdx;
   logic [31:0] wrFloat;
   logic [15:0] wrInt;
   logic rdEn;
   hsmm_idx_t rdIdx;
   logic [47:0] rdData;

   modport store (input wrEn, wrIdx, wrFloat, wrInt, rdEn, rdIdx, output rdData);
   modport user (output wrEn, wrIdx, wrFloat, wrInt, rdEn, rdIdx, input rdData);
endinterface
`default_nettype wire

// ### hdl/hsmm_modbus_map.sv
`timescale 1ns/100ps
`default_nettype none
`include "hsmm_params.svh"
module hsmm_modbus_map import hsmm_pkg::*; #(
   parameter int NUM_MEAS = 6
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // Decoded request
   input wire logic reqValid,
   output logic reqReady,
   input wire logic [7:0] reqFunc,
   input wire logic [15:0] reqAddr,
   input wire logic [15:0] reqQty,
   input wire logic [15:0] reqData0,
   input wire logic [15:0] reqData1,
   // Answer byte stream
   output logic txValid,
   input wire logic txReady,
   output logic [7:0] txByte,
   output logic txLast,
   // Measurement update
   input wire logic measValid,
   output logic measReady,
   input wire logic [2:0] measIdx,
   input wire logic [31:0] measFloat,
   input wire logic [15:0] measInt,
   // Status and settings
   input wire logic calibActive,
   output logic [15:0] slaveAddr,
   output logic [15:0] protoSetting,
   output logic [31:0] workPressure
);

   // ************************************************
   // Address map
   // ************************************************
   localparam logic [15:0] FLT_ADDR [6] = '{
      `HSMM_ADDR_GAS_TEMP, `HSMM_ADDR_REL_HUM, // see RULE4
      `HSMM_ADDR_VAP_PRESS, `HSMM_ADDR_DEW_POINT, // see RULE2 see RULE3
      `HSMM_ADDR_FROST_POINT, `HSMM_ADDR_VOL_CONC // see RULE2 see RULE3
   };

   // Decode one word address
   function automatic hsmm_map_s mapAddr(input logic [15:0] a);
      hsmm_map_s m;
      m = '{kind: K_NONE, idx: 3'h0, hi: 1'b0};
      for (int i = 0; i < 6; i++) begin
         if (a == FLT_ADDR[i]) m = '{kind: K_FLT, idx: 3'(i), hi: 1'b0};
         if (a == FLT_ADDR[i] + 16'h0001) m = '{kind: K_FLT, idx: 3'(i), hi: 1'b1};
         if (a == `HSMM_ADDR_INT_BASE + 16'(i)) m = '{kind: K_INT, idx: 3'(i), hi: 1'b0};
      end
      if (a == `HSMM_ADDR_CALIB) m = '{kind: K_CALIB, idx: 3'h0, hi: 1'b0};
      if (a == `HSMM_ADDR_PRESSURE) m = '{kind: K_PRESS, idx: 3'h0, hi: 1'b0};
      if (a == `HSMM_ADDR_PRESSURE + 16'h0001) m = '{kind: K_PRESS, idx: 3'h0, hi: 1'b1};
      return m;
   endfunction

   // ************************************************
   // State
   // ************************************************
   hsmm_state_e state, next_state;
   logic [7:0] func, next_func;
   logic [6:0] qty, next_qty;
   logic [6:0] cnt, next_cnt;
   logic [6:0] words, next_words;
   logic [15:0] addr, next_addr;
   logic [7:0] hdr [5];
   logic [7:0] next_hdr [5];
   logic [2:0] hdrLen, next_hdrLen;
   logic [2:0] hdrIdx, next_hdrIdx;
   logic [15:0] curWord, next_curWord;
   logic next_txValid, next_txLast;
   logic [7:0] next_txByte;
   logic [15:0] next_slaveAddr, next_protoSetting;
   logic [31:0] next_workPressure;
   hsmm_map_s curMap;
   logic slot;

   hsmm_mem_if memBus ();

   hsmm_meas_mem #(.ENTRIES(NUM_MEAS)) u_mem (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .mem(memBus)
   );

   // Handshakes and memory hookup; updates held off during an answer
   assign reqReady = (state == ST_IDLE);
   assign measReady = (state == ST_IDLE);
   assign slot = !txValid || txReady;
   assign curMap = mapAddr(addr);
   assign memBus.wrEn = measValid && measReady;
   assign memBus.wrIdx = measIdx;
   assign memBus.wrFloat = measFloat;
   assign memBus.wrInt = measInt;
   assign memBus.rdEn = (state == ST_FETCH);
   assign memBus.rdIdx = curMap.idx;

   // ************************************************
   // Request sequencer, next values
   // ************************************************
   always_comb begin
      logic doExc;
      logic [7:0] excCode;
      doExc = 1'b0;
      excCode = 8'h00;
      next_state = state;
      next_func = func;
      next_qty = qty;
      next_cnt = cnt;
      next_words = words;
      next_addr = addr;
      next_hdr = hdr;
      next_hdrLen = hdrLen;
      next_hdrIdx = hdrIdx;
      next_curWord = curWord;
      next_txValid = txValid;
      next_txByte = txByte;
      next_txLast = txLast;
      next_slaveAddr = slaveAddr;
      next_protoSetting = protoSetting;
      next_workPressure = workPressure;
      if (txValid && txReady) begin
         next_txValid = 1'b0;
         next_txLast = 1'b0;
      end
      case (state)
         ST_IDLE: begin
            if (reqValid) begin
               next_func = reqFunc;
               next_addr = reqAddr;
               next_hdrIdx = 3'h0;
               next_words = 7'h00;
               case (reqFunc)
                  `HSMM_FC_RD_HOLD, `HSMM_FC_RD_INPUT: begin // see RULE5
                     if (reqQty == 16'h0000 || reqQty > `HSMM_MAX_QTY) begin
                        doExc = 1'b1;
                        excCode = `HSMM_EX_ILL_VALUE;
                     end else begin
                        next_qty = reqQty[6:0];
                        next_cnt = reqQty[6:0];
                        next_state = ST_SCAN;
                     end
                  end
                  `HSMM_FC_WR_SINGLE: begin
                     // Only the two link words are writable; units stay fixed
                     if (reqAddr == `HSMM_ADDR_SLAVE) begin
                        next_slaveAddr = reqData0; // see RULE7
                     end else if (reqAddr == `HSMM_ADDR_PROTO) begin
                        next_protoSetting = reqData0; // see RULE7
                     end else begin
                        doExc = 1'b1; // see RULE11
                        excCode = `HSMM_EX_ILL_ADDR;
                     end
                     next_hdr = '{reqFunc, reqAddr[15:8], reqAddr[7:0],
                                  reqData0[15:8], reqData0[7:0]};
                     next_hdrLen = 3'h5;
                     next_state = ST_HEAD;
                  end
                  `HSMM_FC_WR_MULTI: begin
                     if (reqAddr == `HSMM_ADDR_PRESSURE && reqQty == `HSMM_PRESS_QTY) begin
                        next_workPressure = {reqData1, reqData0}; // see RULE14 see RULE9
                     end else begin
                        doExc = 1'b1;
                        excCode = `HSMM_EX_ILL_ADDR;
                     end
                     next_hdr = '{reqFunc, reqAddr[15:8], reqAddr[7:0],
                                  reqQty[15:8], reqQty[7:0]};
                     next_hdrLen = 3'h5;
                     next_state = ST_HEAD;
                  end
                  default: begin
                     doExc = 1'b1;
                     excCode = `HSMM_EX_ILL_FUNC;
                  end
               endcase
            end
         end
         ST_SCAN: begin
            // Whole range must be mapped before any data goes out
            if (curMap.kind == K_NONE) begin
               doExc = 1'b1;
               excCode = `HSMM_EX_ILL_ADDR;
            end else if (cnt == 7'h01) begin
               next_hdr[0] = func;
               next_hdr[1] = {qty, 1'b0}; // see RULE15
               next_hdrLen = 3'h2;
               next_words = qty;
               next_addr = addr - 16'({9'h000, qty}) + 16'h0001;
               next_state = ST_HEAD;
            end else begin
               next_cnt = cnt - 7'h01;
               next_addr = addr + 16'h0001;
            end
         end
         ST_HEAD: begin
            if (slot) begin
               next_txValid = 1'b1;
               next_txByte = hdr[hdrIdx];
               next_txLast = (hdrIdx == hdrLen - 3'h1) && (words == 7'h00);
               if (hdrIdx == hdrLen - 3'h1) begin
                  next_hdrIdx = 3'h0;
                  next_state = (words == 7'h00) ? ST_IDLE : ST_FETCH;
               end else begin
                  next_hdrIdx = hdrIdx + 3'h1;
               end
            end
         end
         ST_FETCH: begin
            next_state = ST_LOADW;
         end
         ST_LOADW: begin
            case (curMap.kind)
               K_FLT: begin
                  // Low mantissa half sits at the lower address
                  next_curWord = curMap.hi ? memBus.rdData[47:32]
                                           : memBus.rdData[31:16]; // see RULE9
               end
               K_INT: next_curWord = memBus.rdData[15:0]; // see RULE1
               K_CALIB: next_curWord = {15'h0000, calibActive}; // see RULE6
               K_PRESS: next_curWord = curMap.hi ? workPressure[31:16] : workPressure[15:0];
               default: next_curWord = 16'h0000;
            endcase
            next_state = ST_HI;
         end
         ST_HI: begin
            if (slot) begin
               next_txValid = 1'b1;
               next_txByte = curWord[15:8];
               next_state = ST_LO;
            end
         end
         ST_LO: begin
            if (slot) begin
               next_txValid = 1'b1;
               next_txByte = curWord[7:0];
               next_txLast = (words == 7'h01); // see RULE15
               next_words = words - 7'h01;
               next_addr = addr + 16'h0001;
               next_state = (words == 7'h01) ? ST_IDLE : ST_FETCH;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (doExc) begin
         next_hdr[0] = ((state == ST_IDLE) ? reqFunc : func) | `HSMM_FC_EXC_FLAG;
         next_hdr[1] = excCode;
         next_hdrLen = 3'h2;
         next_hdrIdx = 3'h0;
         next_words = 7'h00;
         next_state = ST_HEAD;
      end
   end

   // Sequencer registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         func <= 8'h00;
         qty <= 7'h00;
         cnt <= 7'h00;
         words <= 7'h00;
         addr <= 16'h0000;
         hdr <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
         hdrLen <= 3'h0;
         hdrIdx <= 3'h0;
         curWord <= 16'h0000;
         txValid <= 1'b0;
         txByte <= 8'h00;
         txLast <= 1'b0;
         slaveAddr <= `HSMM_RST_SLAVE; // see RULE12
         protoSetting <= `HSMM_RST_PROTO;
         workPressure <= `HSMM_RST_PRESSURE; // see RULE14 see RULE10
      end else if (ce) begin
         state <= next_state;
         func <= next_func;
         qty <= next_qty;
         cnt <= next_cnt;
         words <= next_words;
         addr <= next_addr;
         hdr <= next_hdr;
         hdrLen <= next_hdrLen;
         hdrIdx <= next_hdrIdx;
         curWord <= next_curWord;
         txValid <= next_txValid;
         txByte <= next_txByte;
         txLast <= next_txLast;
         slaveAddr <= next_slaveAddr;
         protoSetting <= next_protoSetting;
         workPressure <= next_workPressure;
      end
   end

   // ************************************************
   // Checks
   // ************************************************
   logic wroteSlave;
   hsmm_map_s reqMap;

   // Decode of the address on offer, for the checks only
   assign reqMap = mapAddr(reqAddr);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wroteSlave <= 1'b0;
      end else if (ce && reqReady && reqValid && reqFunc == `HSMM_FC_WR_SINGLE) begin
         wroteSlave <= 1'b1;
      end
   end

   sequence s_take04;
      ce && reqReady && reqValid && !txValid && reqFunc == `HSMM_FC_RD_INPUT
         && reqQty == 16'h0001 && reqMap.kind != K_NONE;
   endsequence
   sequence s_badwr;
      ce && reqReady && reqValid && !txValid && reqFunc == `HSMM_FC_WR_SINGLE
         && reqAddr > `HSMM_ADDR_PROTO;
   endsequence

   property p_slave_rst;
      @(posedge ref_clk) disable iff (rst) !wroteSlave |-> slaveAddr == `HSMM_RST_SLAVE;
   endproperty
   a_slave_rst: assert property (p_slave_rst) else $error("slave address left default"); // see RULE12

   property p_slave_wr;
      @(posedge ref_clk) disable iff (rst)
      $changed(slaveAddr) |-> $past(ce && reqReady && reqValid
         && reqFunc == `HSMM_FC_WR_SINGLE && reqAddr == `HSMM_ADDR_SLAVE);
   endproperty
   a_slave_wr: assert property (p_slave_wr) else $error("slave address changed"); // see RULE7

   property p_press_wr;
      @(posedge ref_clk) disable iff (rst)
      $changed(workPressure) |-> $past(ce && reqReady && reqValid
         && reqFunc == `HSMM_FC_WR_MULTI && reqAddr == `HSMM_ADDR_PRESSURE);
   endproperty
   a_press_wr: assert property (p_press_wr) else $error("pressure changed unasked"); // see RULE14

   property p_float_lo;
      @(posedge ref_clk) disable iff (rst)
      (ce && state == ST_LOADW && curMap.kind == K_FLT && !curMap.hi)
         |=> curWord == $past(memBus.rdData[31:16]);
   endproperty
   a_float_lo: assert property (p_float_lo) else $error("float word order wrong"); // see RULE9

   property p_calib;
      @(posedge ref_clk) disable iff (rst)
      (ce && state == ST_LOADW && curMap.kind == K_CALIB)
         |=> curWord == {15'h0000, $past(calibActive)};
   endproperty
   a_calib: assert property (p_calib) else $error("calibration word wrong"); // see RULE6

   property p_count;
      @(posedge ref_clk) disable iff (rst)
      (ce && state == ST_HEAD && slot && hdrIdx == 3'h1 && words != 7'h00) ##1 ce
         |=> txByte == $past({qty, 1'b0});
   endproperty
   a_count: assert property (p_count) else $error("byte count wrong"); // see RULE15

   property p_fc04;
      @(posedge ref_clk) disable iff (rst)
      s_take04 ##1 ce [*2] |=> (txValid && txByte == `HSMM_FC_RD_INPUT);
   endproperty
   a_fc04: assert property (p_fc04) else $error("input read not answered"); // see RULE5

   property p_badwr;
      @(posedge ref_clk) disable iff (rst)
      s_badwr ##1 ce |=> (txValid && txByte == 8'h86);
   endproperty
   a_badwr: assert property (p_badwr) else $error("bad write not refused"); // see RULE11

endmodule
`default_nettype wire

// ### hdl/hsmm_params.svh
// Summary of operation
// RULE1: Every measured quantity is held both as a 32-bit float and as a 16-bit signed integer.
// RULE2: Dew point float starts at address 0x1F and frost point float at address 0x29.
// RULE3: Volume concentration float starts at 0x3B and vapour partial pressure float at 0x1D.
// RULE4: Relative humidity float starts at 0x1B and gas temperature float at 0x19.
// RULE5: Reads use function 0x03 or 0x04 and both codes are answered the same way.
// RULE6: Address 0x1F4 reads 0 in normal measurement and 1 while self calibration runs.
// RULE7: Slave address word 0x00 and protocol word 0x01 are written with function 0x06.
// RULE8: The master turns one-based register numbers into zero-based addresses by subtracting one.
// RULE9: A float goes out as two words, low mantissa half first, then sign, exponent and high half.
// RULE10: Volume concentration uses a working pressure that the master may write over the link.
// RULE11: The unit system is fixed as delivered and no setting switches it.
// RULE12: After reset the device answers to slave address 243, hex F3.
// RULE13: The master fetches both words of a float in one request so the halves match.
// RULE14: Working pressure is a float at 0x1388, written with function 0x10, default 1013.25.
// RULE15: A one-float read answers with byte count four, then both words in address order.
`ifndef HSMM_PARAMS_SVH
`define HSMM_PARAMS_SVH

// ************************************************
// Register addresses
// ************************************************
`define HSMM_ADDR_SLAVE 16'h0000
`define HSMM_ADDR_PROTO 16'h0001
`define HSMM_ADDR_GAS_TEMP 16'h0019
`define HSMM_ADDR_REL_HUM 16'h001b
`define HSMM_ADDR_VAP_PRESS 16'h001d
`define HSMM_ADDR_DEW_POINT 16'h001f
`define HSMM_ADDR_FROST_POINT 16'h0029
`define HSMM_ADDR_VOL_CONC 16'h003b
`define HSMM_ADDR_INT_BASE 16'h0100
`define HSMM_ADDR_CALIB 16'h01f4
`define HSMM_ADDR_PRESSURE 16'h1388

// ************************************************
// Function and exception codes
// ************************************************
`define HSMM_FC_RD_HOLD 8'h03
`define HSMM_FC_RD_INPUT 8'h04
`define HSMM_FC_WR_SINGLE 8'h06
`define HSMM_FC_WR_MULTI 8'h10
`define HSMM_FC_EXC_FLAG 8'h80
`define HSMM_EX_ILL_FUNC 8'h01
`define HSMM_EX_ILL_ADDR 8'h02
`define HSMM_EX_ILL_VALUE 8'h03

// ************************************************
// Limits and reset values
// ************************************************
`define HSMM_MAX_QTY 16'h007d
`define HSMM_PRESS_QTY 16'h0002
`define HSMM_RST_SLAVE 16'h00f3
`define HSMM_RST_PROTO 16'h0000
`define HSMM_RST_PRESSURE 32'h447d5000

`endif

// ### hdl/hsmm_pkg.sv
`default_nettype none
package hsmm_pkg;

   // ************************************************
   // Sequencer states, one-hot
   // ************************************************
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_SCAN = 7'h02,
      ST_HEAD = 7'h04,
      ST_FETCH = 7'h08,
      ST_LOADW = 7'h10,
      ST_HI = 7'h20,
      ST_LO = 7'h40
   } hsmm_state_e;

   // ************************************************
   // Address decode result
   // ************************************************
   typedef enum logic [2:0] {
      K_NONE = 3'h0,
      K_FLT = 3'h1,
      K_INT = 3'h2,
      K_CALIB = 3'h3,
      K_PRESS = 3'h4
   } hsmm_kind_e;

   typedef logic [2:0] hsmm_idx_t;

   typedef struct packed {
      hsmm_kind_e kind;
      hsmm_idx_t idx;
      logic hi;
   } hsmm_map_s;

endpackage
`default_nettype wire

// ### sim/hsmm_master_sink.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************
// Answer sink of the bus master
// ************************************************
module hsmm_master_sink (
   // Clock
   input wire logic ref_clk,
   // Answer stream
   input wire logic txValid,
   output logic txReady,
   input wire logic [7:0] txByte,
   input wire logic txLast,
   // Pacing
   input wire logic slow
);
   logic [7:0] rxQ[$];
   int nDone = 0;
   initial txReady = 1'b0;
   // Ready moves at falling edge, random stalls when slow
   always @(negedge ref_clk) begin
      txReady <= slow ? ($urandom_range(2) != 0) : 1'b1;
   end
   // Collect accepted bytes, count whole answers
   always @(posedge ref_clk) begin
      if (txValid && txReady) begin
         rxQ.push_back(txByte);
         if (txLast) begin
            nDone++;
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/test_humidity_sensor_modbus_map.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) report(32'(g), 32'(e));
module test_humidity_sensor_modbus_map import hsmm_pkg::*;;
   logic ref_clk = 1'b0, rst = 1'b0, ce = 1'b1, slow = 1'b0;
   logic reqValid = 1'b0, measValid = 1'b0, calibActive = 1'b0;
   logic reqReady, measReady, txValid, txReady, txLast;
   logic [7:0] reqFunc = 8'h00, txByte;
   logic [15:0] reqAddr = 16'h0000, reqQty = 16'h0000;
   logic [15:0] reqData0 = 16'h0000, reqData1 = 16'h0000;
   logic [2:0] measIdx = 3'h0;
   logic [31:0] measFloat = 32'h0, workPressure;
   logic [15:0] measInt = 16'h0, slaveAddr, protoSetting;
   int n_mismatch = 0, n_checks = 0;
   int regNum[6] = '{26, 28, 30, 32, 42, 60};
   int fb[6] = '{'h19, 'h1b, 'h1d, 'h1f, 'h29, 'h3b};
   // Reference model state
   logic [31:0] mFlt[6], mPress = 32'h447d5000;
   logic [15:0] mInt[6], mSlave = 16'h00f3, mProto = 16'h0000;
   logic [7:0] expQ[$];

   always #12.5 ref_clk = ~ref_clk;

   hsmm_modbus_map dut_u (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reqValid(reqValid),
      .reqReady(reqReady), .reqFunc(reqFunc), .reqAddr(reqAddr), .reqQty(reqQty),
      .reqData0(reqData0), .reqData1(reqData1), .txValid(txValid), .txReady(txReady),
      .txByte(txByte), .txLast(txLast), .measValid(measValid), .measReady(measReady),
      .measIdx(measIdx), .measFloat(measFloat), .measInt(measInt),
      .calibActive(calibActive), .slaveAddr(slaveAddr), .protoSetting(protoSetting),
      .workPressure(workPressure));
   hsmm_master_sink sink_u (.ref_clk(ref_clk), .txValid(txValid), .txReady(txReady),
      .txByte(txByte), .txLast(txLast), .slow(slow));

   // ************************************************
   // Checking and reference model
   // ************************************************
   task automatic report(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Word at one address, bit 16 set when mapped
   function automatic logic [16:0] mWord(input int a);
      logic [16:0] w;
      w = 17'h0;
      for (int k = 0; k < 6; k++) begin
         if (a == fb[k]) w = {1'b1, mFlt[k][15:0]};
         if (a == fb[k] + 1) w = {1'b1, mFlt[k][31:16]};
         if (a == 'h100 + k) w = {1'b1, mInt[k]};
      end
      if (a == 'h1f4) w = {1'b1, 15'h0, calibActive};
      if (a == 'h1388) w = {1'b1, mPress[15:0]};
      if (a == 'h1389) w = {1'b1, mPress[31:16]};
      return w;
   endfunction

   // Expected answer bytes and setting updates
   task automatic mExpect(input logic [7:0] f, input int a, input int q,
         input logic [15:0] d0, input logic [15:0] d1);
      int bad;
      logic [16:0] w;
      bad = 0;
      expQ = {};
      if (f == 8'h03 || f == 8'h04) begin
         expQ = '{f, 8'(2 * q)};
         for (int i = 0; i < q; i++) begin
            w = mWord(a + i);
            if (w[16] == 1'b0) bad = 2;
            expQ.push_back(w[15:8]);
            expQ.push_back(w[7:0]);
         end
         if (q == 0 || q > 125) bad = 3;
      end else if (f == 8'h06) begin
         bad = (a > 1) ? 2 : 0;
         expQ = '{f, 8'h00, 8'(a), d0[15:8], d0[7:0]};
         if (bad == 0 && a == 0) mSlave = d0;
         if (bad == 0 && a == 1) mProto = d0;
      end else if (f == 8'h10) begin
         bad = (a != 'h1388 || q != 2) ? 2 : 0;
         expQ = '{f, 8'h13, 8'h88, 8'h00, 8'h02};
         if (bad == 0) mPress = {d1, d0};
      end else begin
         bad = 1;
      end
      if (bad != 0) expQ = '{f | 8'h80, 8'(bad)};
   endtask

   // ************************************************
   // Master side drivers
   // ************************************************
   task automatic request(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q,
         input logic [15:0] d0, input logic [15:0] d1);
      int n0, t;
      mExpect(f, a, q, d0, d1);
      n0 = sink_u.nDone;
      sink_u.rxQ.delete();
      t = 0;
      @(negedge ref_clk);
      while (reqReady !== 1'b1 && t < 500) begin
         @(negedge ref_clk);
         t++;
      end
      reqValid = 1'b1;
      reqFunc = f;
      reqAddr = a;
      reqQty = q;
      reqData0 = d0;
      reqData1 = d1;
      @(negedge ref_clk);
      reqValid = 1'b0;
      reqAddr = ~a;
      reqQty = ~q;
      reqData0 = ~d0;
      reqData1 = ~d1;
      t = 0;
      while (sink_u.nDone == n0 && t < 3000) begin
         @(negedge ref_clk);
         t++;
      end
      // Answer that never completed counts as a mismatch
      if (t >= 3000) n_mismatch++;
      `CHK(sink_u.rxQ.size(), expQ.size())
      for (int i = 0; i < expQ.size() && i < sink_u.rxQ.size(); i++) begin
         `CHK(sink_u.rxQ[i], expQ[i])
      end
      `CHK(slaveAddr, mSlave)
      `CHK(protoSetting, mProto)
      `CHK(workPressure, mPress)
   endtask

   task automatic meas(input int k);
      @(negedge ref_clk);
      while (measReady !== 1'b1) @(negedge ref_clk);
      measValid = 1'b1;
      measIdx = 3'(k);
      measFloat = $urandom;
      measInt = 16'($urandom);
      mFlt[k] = measFloat;
      mInt[k] = measInt;
      @(negedge ref_clk);
      measValid = 1'b0;
      measFloat = ~measFloat;
   endtask

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      void'($urandom(57));
      // Raised after time zero so the reset edge is seen
      #1 rst = 1'b1;
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      `CHK(slaveAddr, 16'h00f3)
      `CHK(workPressure, 32'h447d5000)
      for (int k = 0; k < 6; k++) meas(k);
      for (int k = 0; k < 6; k++) begin
         request(8'h03, 16'(regNum[k] - 1), 16'h2, 16'h0, 16'h0);
         request(8'h04, 16'(regNum[k] - 1), 16'h2, 16'h0, 16'h0);
      end
      request(8'h03, 16'h0100, 16'h6, 16'h0, 16'h0);
      slow = 1'b1;
      meas(0);
      request(8'h04, 16'h0019, 16'h8, 16'h0, 16'h0);
      calibActive = 1'b1;
      request(8'h03, 16'h01f4, 16'h1, 16'h0, 16'h0);
      calibActive = 1'b0;
      request(8'h04, 16'h01f4, 16'h1, 16'h0, 16'h0);
      request(8'h06, 16'h0000, 16'h1, 16'($urandom), 16'h0);
      request(8'h06, 16'h0001, 16'h1, 16'($urandom), 16'h0);
      request(8'h03, 16'h0000, 16'h1, 16'h0, 16'h0);
      request(8'h06, 16'h0002, 16'h1, 16'h0001, 16'h0);
      request(8'h10, 16'h1388, 16'h2, 16'($urandom), 16'($urandom));
      request(8'h03, 16'h1388, 16'h2, 16'h0, 16'h0);
      request(8'h10, 16'h1389, 16'h2, 16'h1234, 16'h5678);
      request(8'h05, 16'h0019, 16'h2, 16'h0, 16'h0);
      request(8'h03, 16'h0019, 16'h0, 16'h0, 16'h0);
      request(8'h04, 16'h0019, 16'h7e, 16'h0, 16'h0);
      request(8'h03, 16'h0021, 16'h1, 16'h0, 16'h0);
      print_verdict;
   end

   // Watchdog, about a hundred times the expected run length
   initial begin
      #(25 * 40000);
      n_mismatch++;
      print_verdict;
   end
endmodule
`default_nettype wire
